// *** pkg/tape_load_pkg.sv ***
/*
  Shared constants and carrier types for the tape thread/load sequencer:
  delay counter decodes, reel speeds, register offsets and signal groups.
  Assumes a single 250 MHz logic clock and sensors already synchronous to it.
*/
package tape_load_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ      = 250;
  localparam int TICK_MS      = 23;
  localparam int TICK_CYCLES  = TICK_MS * 1000 * CLK_MHZ;
  localparam int CNT_W        = 8;
  localparam int STAGE_W      = 4;
  localparam int MARK_PULSE   = 2;

  // delay counter decode points
  localparam logic [7:0] CNT_FP_SAMPLE = 8'h20;
  localparam logic [7:0] CNT_HS_DELAY  = 8'h30;
  localparam logic [7:0] CNT_TAPE_CHK  = 8'h40;
  localparam logic [7:0] CNT_LOAD_END  = 8'h74;
  localparam logic [7:0] CNT_THREAD_END = 8'h80;

  // reel speeds while threading, in r/min
  localparam logic [7:0] SUPPLY_THREAD_RPM = 8'h3c;
  localparam logic [7:0] TAKEUP_THREAD_RPM = 8'h8c;

  // ****************************************
  // register map
  // ****************************************
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  REG_STATUS  = 4'h0;
  localparam logic [3:0]  REG_CONTROL = 4'h4;
  localparam logic [3:0]  REG_COUNT   = 4'h8;
  localparam int          CTRL_LOAD_EN = 0;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {OP_IDLE, OP_LOAD, OP_LOADED} op_t;

  typedef struct packed {
    logic hub_lock;
    logic window_close;
    logic load_delay;
    logic load;
    logic writable;
    logic thread;
    logic reels_loaded;
    logic load_cols;
    logic cols_loaded;
    logic search;
    logic rewind;
    logic hs_step;
    logic high_speed;
    logic at_load_point;
    logic thread_check;
    logic sot_seen;
    logic start_seen;
  } latches_t;

  typedef struct packed {
    logic load_pb;
    logic start_pb;
    logic reset_pb;
    logic write_ring;
    logic tape_present;
    logic taut;
    logic cols_at_zone;
    logic start_of_tape_marker;
    logic slowdown_zone_sensor;
  } sensors_t;

  typedef struct packed {
    logic       hub_lock;
    logic       window_close;
    logic       pneu_power;
    logic       thread_pressure;
    logic       cartridge_open;
    logic       supply_cw;
    logic       takeup_cw;
    logic [7:0] supply_rpm;
    logic [7:0] takeup_rpm;
    logic       column_vacuum;
    logic       column_control;
    logic       go;
    logic       backward;
    logic       high_speed;
    logic       tape_in_head;
    logic       internal_ready;
    logic       ready;
    logic       writable;
    logic       write_inhibit;
    logic       thread_check;
  } actuators_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              we;
    logic              re;
  } bus_req_t;

endpackage

// *** rtl/delay_counter.sv ***
/*
  Eight-bit delay counter: two four-bit stages advanced by a free-running
  tick derived from the logic clock. Assumes clear has priority over counting.
*/
`timescale 1ns/1ps
module delay_counter #(
  parameter int TICK_CYCLES = tape_load_pkg::TICK_CYCLES
) (
  input  wire logic                          clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          ce_i,
  input  wire logic                          run_i,
  input  wire logic                          clear_i,
  output logic      [tape_load_pkg::CNT_W-1:0] taps_o
);
  import tape_load_pkg::*;

  if (TICK_CYCLES < 1) begin : g_bad
    $error("tick period must be at least one cycle");
  end

  typedef struct packed {
    logic [31:0]      pre;
    logic [CNT_W-1:0] cnt;
  } dc_st_t;

  dc_st_t q;
  dc_st_t d;
  logic   tick;
  logic [CNT_W/STAGE_W:0] carry;

  // the oscillator runs free, so a restart can land anywhere within a tick period
  assign tick     = (q.pre == 32'(TICK_CYCLES - 1));
  assign carry[0] = tick & run_i;

  // ****************************************
  // stages
  // ****************************************
  for (genvar s = 0; s < CNT_W / STAGE_W; s++) begin : g_stage
    assign carry[s+1] = carry[s] & (&q.cnt[s*STAGE_W +: STAGE_W]);
  end

  always_comb begin
    d     = q;
    d.pre = tick ? 32'h0 : q.pre + 32'h1;
    for (int s = 0; s < CNT_W / STAGE_W; s++) begin
      if (carry[s]) begin
        d.cnt[s*STAGE_W +: STAGE_W] = q.cnt[s*STAGE_W +: STAGE_W] + 4'h1;
      end
    end
    if (clear_i) begin
      d.cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign taps_o = q.cnt;

endmodule

// *** rtl/marker_edge.sv ***
/*
  Trailing-edge detector for the start-of-tape marker sensor. Gives a
  stretched marker pulse and a copy of it one cycle later.
  Assumes the sensor level is synchronous to the clock.
*/
`timescale 1ns/1ps
module marker_edge #(
  parameter int PULSE_LEN = tape_load_pkg::MARK_PULSE
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  input  wire logic marker_i,
  output logic      pulse_o,
  output logic      delayed_o
);
  import tape_load_pkg::*;

  if (PULSE_LEN < 2 || PULSE_LEN > 15) begin : g_bad
    $error("pulse must last 2 to 15 cycles to overlap its delayed copy");
  end

  typedef struct packed {
    logic       prev;
    logic [3:0] left;
    logic       dly;
  } me_st_t;

  me_st_t q;
  me_st_t d;

  always_comb begin
    d      = q;
    d.prev = marker_i;
    d.dly  = (q.left != 4'h0);
    if (q.prev && !marker_i) begin
      d.left = 4'(PULSE_LEN);
    end else if (q.left != 4'h0) begin
      d.left = q.left - 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign pulse_o   = (q.left != 4'h0);
  assign delayed_o = q.dly;

endmodule

// *** rtl/tape_thread_load_sequencer.sv ***
/*
  Thread/load sequencer of a reel-to-reel tape unit: latches, delay-count
  decodes, actuator commands and a small register port.
  Assumes pushbuttons and sensors arrive synchronous to clk_i and debounced.
*/
`timescale 1ns/1ps
module tape_thread_load_sequencer #(
  parameter int TICK_CYCLES = tape_load_pkg::TICK_CYCLES
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      ce_i,
  input  wire tape_load_pkg::sensors_t   sense_i,
  input  wire tape_load_pkg::bus_req_t   bus_i,
  output tape_load_pkg::actuators_t      act_o,
  output logic [31:0]                    rd_data_o
);
  import tape_load_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    op_t         op;
    latches_t    lat;
    logic        redet;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    actuators_t  act;
  } seq_st_t;

  seq_st_t          q;
  seq_st_t          d;
  logic             clr_cnt;
  logic             run_cnt;
  logic [CNT_W-1:0] taps;
  logic             mark_pulse;
  logic             mark_dly;

  // the counter value is one AND of true and inverted taps
  function automatic logic at_count(input logic [CNT_W-1:0] t,
                                    input logic [CNT_W-1:0] v);
    at_count = &(~(t ^ v));
  endfunction

  function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a,
                                           input seq_st_t s,
                                           input logic [CNT_W-1:0] t);
    case (a)
      REG_STATUS:  read_mux = {13'h0, s.op, s.lat};
      REG_CONTROL: read_mux = s.ctrl;
      REG_COUNT:   read_mux = {24'h0, t};
      default:     read_mux = 32'h0;
    endcase
  endfunction

  // ****************************************
  // timing and marker
  // ****************************************
  assign run_cnt = (q.op == OP_LOAD);

  delay_counter #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_dc (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .run_i     (run_cnt),
    .clear_i   (clr_cnt),
    .taps_o    (taps)
  );

  marker_edge #(
    .PULSE_LEN (MARK_PULSE)
  ) u_mark (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .marker_i  (sense_i.start_of_tape_marker),
    .pulse_o   (mark_pulse),
    .delayed_o (mark_dly)
  );

  // ****************************************
  // sequence
  // ****************************************
  always_comb begin
    d       = q;
    clr_cnt = 1'b0;

    if (bus_i.we && bus_i.addr == REG_CONTROL) begin
      d.ctrl = bus_i.wdata;
    end
    d.rdata = bus_i.re ? read_mux(bus_i.addr, q, taps) : 32'h0;

    if (sense_i.start_pb) begin
      d.lat.start_seen = 1'b1;
    end else if (sense_i.reset_pb) begin
      d.lat.start_seen = 1'b0;
    end

    case (q.op)
      OP_IDLE: begin
        // the load pushbutton only acts while no operation runs and load is enabled
        if (sense_i.load_pb && q.ctrl[CTRL_LOAD_EN]) begin
          d.lat              = '0;
          d.lat.start_seen   = q.lat.start_seen | sense_i.start_pb;
          d.lat.hub_lock     = 1'b1;
          d.lat.window_close = 1'b1;
          d.lat.load_delay   = 1'b1;
          d.lat.load         = 1'b1;
          d.redet            = 1'b0;
          d.op               = OP_LOAD;
          clr_cnt            = 1'b1;
        end
      end
      OP_LOAD: begin
        if (sense_i.reset_pb) begin
          // abort: drop every motion latch, keep hub and window as they are
          d.lat.load_delay   = 1'b0;
          d.lat.load         = 1'b0;
          d.lat.thread       = 1'b0;
          d.lat.reels_loaded = 1'b0;
          d.lat.load_cols    = 1'b0;
          d.lat.cols_loaded  = 1'b0;
          d.lat.search       = 1'b0;
          d.lat.rewind       = 1'b0;
          d.lat.hs_step      = 1'b0;
          d.lat.high_speed   = 1'b0;
          d.op               = OP_IDLE;
          clr_cnt            = 1'b1;
        end else begin
          if (q.lat.load_delay && at_count(taps, CNT_FP_SAMPLE)) begin
            d.lat.writable = sense_i.write_ring;
          end
          if (q.lat.load_delay && at_count(taps, CNT_LOAD_END)) begin
            d.lat.load_delay = 1'b0;
            d.lat.thread     = 1'b1;
            clr_cnt          = 1'b1;
          end

          if (q.lat.thread && !q.lat.reels_loaded) begin
            if (sense_i.taut) begin
              d.lat.reels_loaded = 1'b1;
              clr_cnt            = 1'b1;
            end else if ((at_count(taps, CNT_TAPE_CHK) && !sense_i.tape_present) ||
                         at_count(taps, CNT_THREAD_END)) begin
              // retry is not handled here: a failed thread halts the load
              d.lat.thread_check = 1'b1;
              d.lat.thread       = 1'b0;
              d.lat.load         = 1'b0;
              d.op               = OP_IDLE;
              clr_cnt            = 1'b1;
            end
          end

          if (q.lat.thread && q.lat.reels_loaded && at_count(taps, CNT_THREAD_END)) begin
            d.lat.thread       = 1'b0;
            d.lat.reels_loaded = 1'b0;
            d.lat.load_cols    = 1'b1;
            clr_cnt            = 1'b1;
          end

          // a short leader lets the marker pass before search begins
          if ((q.lat.thread || q.lat.load_cols) && mark_pulse) begin
            d.lat.sot_seen = 1'b1;
          end

          if (q.lat.load_cols && sense_i.cols_at_zone) begin
            d.lat.cols_loaded = 1'b1;
            d.lat.load_cols   = 1'b0;
            clr_cnt           = 1'b1;
            if (q.lat.sot_seen) begin
              d.lat.rewind  = 1'b1;
              d.lat.hs_step = 1'b1;
              d.redet       = 1'b0;
            end else begin
              d.lat.search  = 1'b1;
            end
          end

          if (q.lat.search && mark_pulse) begin
            d.lat.search  = 1'b0;
            d.lat.rewind  = 1'b1;
            d.lat.hs_step = 1'b1;
            d.redet       = 1'b0;
            clr_cnt       = 1'b1;
          end

          // the pulse that ended search is still live as rewind begins, so only
          // a marker seen since rewind started may end the load
          if (q.lat.rewind && sense_i.start_of_tape_marker) begin
            d.redet = 1'b1;
          end
          if (q.lat.rewind && q.lat.hs_step) begin
            if (at_count(taps, CNT_HS_DELAY) && !q.redet && !sense_i.start_of_tape_marker) begin
              d.lat.high_speed = 1'b1;
            end
          end

          if (q.lat.rewind && sense_i.slowdown_zone_sensor) begin
            d.lat.hs_step    = 1'b0;
            d.lat.high_speed = 1'b0;
          end

          if (q.lat.rewind && q.redet && !q.lat.high_speed && mark_pulse && mark_dly) begin
            d.lat.at_load_point = 1'b1;
            d.lat.rewind        = 1'b0;
            d.lat.hs_step       = 1'b0;
            d.lat.load          = 1'b0;
            d.op                = OP_LOADED;
            clr_cnt             = 1'b1;
          end
        end
      end
      OP_LOADED: begin
        d.op = OP_LOADED;
      end
      default: begin
        d.op = OP_IDLE;
      end
    endcase

    // ****************************************
    // actuator commands
    // ****************************************
    d.act.hub_lock        = d.lat.hub_lock;
    d.act.window_close    = d.lat.window_close;
    d.act.pneu_power      = (d.op != OP_IDLE);
    d.act.thread_pressure = d.lat.load_delay | d.lat.thread;
    d.act.cartridge_open  = (d.op == OP_LOAD);
    d.act.supply_cw       = d.lat.thread | d.lat.load_cols;
    d.act.takeup_cw       = d.lat.thread;
    d.act.supply_rpm      = (d.lat.thread | d.lat.load_cols) ? SUPPLY_THREAD_RPM : 8'h00;
    d.act.takeup_rpm      = (d.lat.thread | d.lat.load_cols) ? TAKEUP_THREAD_RPM : 8'h00;
    d.act.column_vacuum   = d.lat.load_cols | d.lat.cols_loaded;
    d.act.column_control  = d.lat.cols_loaded;
    d.act.go              = d.lat.search | d.lat.rewind;
    d.act.backward        = d.lat.rewind;
    d.act.high_speed      = d.lat.high_speed;
    d.act.tape_in_head    = sense_i.tape_present;
    d.act.internal_ready  = (d.op == OP_LOADED);
    d.act.ready           = (d.op == OP_LOADED) & d.lat.start_seen;
    d.act.writable        = d.lat.writable;
    d.act.write_inhibit   = ~d.lat.writable;
    d.act.thread_check    = d.lat.thread_check;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q      <= '0;
      q.op   <= OP_IDLE;
      q.ctrl <= CTRL_RESET;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign act_o     = q.act;
  assign rd_data_o = q.rdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_load_press;
    ce_i && q.op == OP_IDLE && sense_i.load_pb && q.ctrl[CTRL_LOAD_EN];
  endsequence

  sequence s_live_load;
    ce_i && q.op == OP_LOAD && !sense_i.reset_pb;
  endsequence

  sequence s_search_hit;
    s_live_load ##0 q.lat.search && mark_pulse;
  endsequence

  a_load_press: assert property (s_load_press |=> q.lat.load && q.lat.load_delay &&
      q.act.window_close && q.op == OP_LOAD)
    else $error("load press did not start the load");

  a_load_pneu: assert property (q.lat.load |-> q.act.pneu_power && q.act.cartridge_open)
    else $error("load latch without pneumatics or cartridge open");

  a_ring_sample: assert property (s_live_load ##0 q.lat.load_delay &&
      at_count(taps, CNT_FP_SAMPLE) && !sense_i.write_ring |=> q.act.write_inhibit)
    else $error("write allowed without ring");

  a_thread_entry: assert property (s_live_load ##0 q.lat.load_delay &&
      at_count(taps, CNT_LOAD_END) |=> q.lat.thread && !q.lat.load_delay ##0 taps == 8'h00)
    else $error("thread latch not entered at count 116");

  a_thread_reels: assert property (q.lat.thread |-> q.act.supply_cw && q.act.takeup_cw &&
      q.act.supply_rpm == 8'h3c && q.act.takeup_rpm == 8'h8c)
    else $error("wrong reel command while threading");

  a_cols_handoff: assert property (s_live_load ##0 q.lat.load_cols && sense_i.cols_at_zone
      |=> q.lat.cols_loaded && !q.lat.load_cols && (q.lat.search || q.lat.rewind))
    else $error("columns loaded did not hand over");

  a_search_go: assert property (q.lat.search |-> q.act.go && !q.act.backward)
    else $error("search without forward motion request");

  a_search_rewind: assert property (s_search_hit |=> q.lat.rewind && q.lat.hs_step &&
      !q.lat.search ##1 q.act.backward)
    else $error("marker pulse in search did not set rewind");

  a_slowdown_drop: assert property (s_live_load ##0 q.lat.rewind &&
      sense_i.slowdown_zone_sensor |=> !q.lat.high_speed && !q.lat.hs_step)
    else $error("slowdown zone did not drop high speed");

  a_ready_gate: assert property (q.act.ready |-> q.act.internal_ready && q.lat.start_seen)
    else $error("ready without loaded and start");

  a_clear_count: assert property (ce_i && clr_cnt |=> taps == 8'h00)
    else $error("delay counter not cleared");

endmodule

// *** tb/tape_path_model.sv ***
/*
  Tape path and controller stand-in: reels, columns and marker sensors react
  to the actuator outputs; a write to an unwritable unit is flagged.
  Assumes one clock, sensors sampled by the sequencer on the same edge.
*/
`timescale 1ns/1ps
module tape_path_model
  import tape_load_pkg::*;
(
  input  wire logic       clk_i,
  input  wire actuators_t act_i,
  input  wire logic       short_i,
  input  wire logic       taut_en_i,
  input  wire logic [9:0] rew_dly_i,
  input  wire logic       wr_cmd_i,
  output logic            tape_present_o,
  output logic            taut_o,
  output logic            zone_o,
  output logic            marker_o,
  output logic            slow_o,
  output logic            reject_o
);
  int   t;
  int   v;
  int   s;
  int   r;
  logic in_path_q;
  always_ff @(posedge clk_i) begin
    t <= (act_i.supply_cw && act_i.takeup_cw) ? t + 1 : 0;
    v <= act_i.column_vacuum ? v + 1 : 0;
    s <= (act_i.go && !act_i.backward) ? s + 1 : 0;
    r <= act_i.backward ? r + 1 : 0;
    in_path_q <= act_i.pneu_power && (in_path_q || t > 20);
  end
  assign tape_present_o = in_path_q;
  assign taut_o = taut_en_i && t > 60;
  assign zone_o = v > 30;
  // a short leader lets the marker pass while threading
  assign marker_o = (short_i && t >= 30 && t < 40) || (s >= 40 && s < 50)
                    || (r >= rew_dly_i && r < rew_dly_i + 10);
  assign slow_o = act_i.high_speed && r + 20 >= rew_dly_i && r + 10 < rew_dly_i;
  assign reject_o = wr_cmd_i && !act_i.writable;
endmodule

// *** tb/tb_tape_thread_load_sequencer.sv ***
/*
  Self-checking bench for the thread/load sequencer: timing model in integers.
  Assumes the tape path model on the sensor side and a short tick.
*/
`timescale 1ns/1ps
module tb_tape_thread_load_sequencer;
  import tape_load_pkg::*;
  localparam int T = 4;
  logic        clk_i;
  logic        reset_n_i;
  logic        ce_i;
  logic        load_pb;
  logic        start_pb;
  logic        rst_pb;
  logic        ring;
  logic        short_l;
  logic        taut_en;
  logic [9:0]  rew_dly;
  logic        tp;
  logic        taut;
  logic        zone;
  logic        mark;
  logic        slow;
  logic        reject;
  sensors_t    sense;
  bus_req_t    bus;
  actuators_t  act;
  logic [31:0] rd;
  logic [31:0] seed;
  int          failures;
  int          checked;
  int          cyc;

  assign sense = {load_pb, start_pb, rst_pb, ring, tp, taut, zone, mark, slow};
  tape_thread_load_sequencer #(.TICK_CYCLES(T)) tape_thread_load_sequencer_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .sense_i(sense),
    .bus_i(bus), .act_o(act), .rd_data_o(rd));
  tape_path_model tape_path_model_i (
    .clk_i(clk_i), .act_i(act), .short_i(short_l), .taut_en_i(taut_en),
    .rew_dly_i(rew_dly), .wr_cmd_i(1'b1), .tape_present_o(tp), .taut_o(taut),
    .zone_o(zone), .marker_o(mark), .slow_o(slow), .reject_o(reject));

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic give_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // phase of the free tick is arbitrary, so spans get a small window
  task automatic cmp_time(input int got, input int exp);
    checked++;
    if (got < exp - 8 || got > exp + 8) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic bus_op(input logic w, input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= 32'hffff_ffff;
    bus.we <= w;
    bus.re <= !w;
    @(posedge clk_i);
    bus.we <= 1'b0;
    bus.re <= 1'b0;
    #1 d = rd;
  endtask
  task automatic pulse(input logic ld);
    @(posedge clk_i);
    load_pb <= ld;
    start_pb <= !ld;
    @(posedge clk_i);
    load_pb <= 1'b0;
    start_pb <= 1'b0;
    #1;
  endtask

  // ****************************************
  // one load sequence
  // ****************************************
  task automatic run(input logic r, sl, te, st, input logic [9:0] rdl);
    int          t0;
    int          hs;
    logic [3:0]  a;
    logic [31:0] v0;
    logic [31:0] v1;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    ring <= r;
    short_l <= sl;
    taut_en <= te;
    rew_dly <= rdl;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1 cmp_val(32'(|act), 32'h0);
    bus_op(1'b1, 4'h0, v0);
    bus_op(1'b0, 4'h0, v0);
    cmp_val(v0, 32'h0);
    repeat (3) begin
      seed = xs(seed);
      a = (seed[3:0] == 4'h0 || seed[3:0] == 4'h8) ? 4'h4 : seed[3:0];
      bus_op(1'b0, a, v0);
      cmp_val(v0, (a == 4'h4) ? 32'h1 : 32'h0);
    end
    if (st) pulse(1'b0);
    repeat (seed[7:4]) @(posedge clk_i);
    pulse(1'b1);
    t0 = cyc;
    step();
    cmp_val({act.hub_lock, act.window_close, act.pneu_power, act.thread_pressure,
             act.cartridge_open}, 32'h1f);
    bus_op(1'b0, 4'h8, v0);
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (29) @(posedge clk_i);
    bus_op(1'b0, 4'h8, v1);
    cmp_val(v1 - v0, 32'h8);
    pulse(1'b1);
    while (act.supply_rpm !== 8'h3c && cyc - t0 < 900) step();
    cmp_time(cyc - t0, 116 * T + 20);
    cmp_val({act.supply_cw, act.takeup_cw, act.supply_rpm, act.takeup_rpm},
            {2'b11, 8'h3c, 8'h8c});
    cmp_val({act.writable, act.write_inhibit, reject}, {r, !r, !r});
    t0 = cyc;
    if (!te) begin
      while (act.thread_check !== 1'b1 && cyc - t0 < 900) step();
      cmp_time(cyc - t0, 128 * T);
      pulse(1'b1);
      @(posedge clk_i);
      rst_pb <= 1'b1;
      @(posedge clk_i);
      rst_pb <= 1'b0;
      #1 cmp_val({act.pneu_power, act.hub_lock, act.thread_pressure}, 32'h2);
      return;
    end
    while (act.tape_in_head !== 1'b1 && cyc - t0 < 100) step();
    cmp_time(cyc - t0, 23);
    while (taut !== 1'b1 && cyc - t0 < 200) step();
    t0 = cyc;
    while (act.takeup_cw !== 1'b0 && cyc - t0 < 900) step();
    cmp_time(cyc - t0, 128 * T);
    cmp_val({act.supply_cw, act.takeup_cw, act.column_vacuum}, 32'h5);
    while (act.column_control !== 1'b1 && cyc - t0 < 1000) step();
    repeat (4) step();
    cmp_val({act.go, act.backward}, {1'b1, sl});
    while (act.backward !== 1'b1 && cyc - t0 < 1200) step();
    t0 = cyc;
    hs = 0;
    while (act.internal_ready !== 1'b1 && cyc - t0 < 900) begin
      if (act.high_speed === 1'b1 && hs == 0) hs = cyc - t0;
      step();
    end
    cmp_time(cyc - t0, rdl + 12);
    cmp_time(hs, (rdl > 300) ? 48 * T : 0);
    cmp_val({act.go, act.internal_ready, act.ready, act.high_speed},
            {1'b0, 1'b1, st, 1'b0});
    bus_op(1'b0, 4'h0, v0);
    cmp_val(v0[18:17], 32'h2);
    pulse(1'b0);
    step();
    cmp_val(act.ready, 32'h1);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    load_pb = 1'b0;
    start_pb = 1'b0;
    rst_pb = 1'b0;
    ring = 1'b0;
    short_l = 1'b0;
    taut_en = 1'b1;
    rew_dly = 10'h0;
    bus = '0;
    seed = 32'ha7e02caf;
    run(1'b1, 1'b0, 1'b1, 1'b1, 10'h190);
    run(1'b0, 1'b1, 1'b1, 1'b0, 10'h03c);
    run(1'b1, 1'b0, 1'b0, 1'b0, 10'h03c);
    give_verdict();
  end
  // three loads take well under 10,000 cycles
  initial begin
    #300000;
    failures++;
    give_verdict();
  end
endmodule
